// file: logic/sdm_pkg.sv
// Shared constants and types of the sectored data memory decoder
`default_nettype none
package sdm_pkg;

  // Sector and offset layout of the 12-bit data address
  localparam int SDM_SECTOR_W = 4;
  localparam int SDM_OFFSET_W = 8;
  localparam int SDM_ADDR_W = 12;
  localparam int SDM_SECTORS = 16;
  localparam int SDM_SFR_SECTORS = 2;
  localparam int SDM_DATA_W = 8;

  // Area boundaries inside a sector
  localparam logic [7:0] SDM_SFR_FIRST = 8'h00;
  localparam logic [7:0] SDM_SFR_LAST = 8'h7F;
  localparam logic [7:0] SDM_GP_FIRST = 8'h80;
  localparam logic [7:0] SDM_GP_LAST = 8'hFF;
  localparam int SDM_GP_SELECT_BIT = 7;

  // Indirect ports and pointer bytes, all in sector 0
  localparam logic [7:0] SDM_OFF_PORT_ZERO = 8'h00;
  localparam logic [7:0] SDM_OFF_PTR_ZERO = 8'h01;
  localparam logic [7:0] SDM_OFF_PORT_ONE = 8'h02;
  localparam logic [7:0] SDM_OFF_PTR_ONE_OFS = 8'h03;
  localparam logic [7:0] SDM_OFF_PTR_ONE_SEC = 8'h04;
  localparam logic [7:0] SDM_OFF_PORT_TWO = 8'h0C;
  localparam logic [7:0] SDM_OFF_PTR_TWO_OFS = 8'h0D;
  localparam logic [7:0] SDM_OFF_PTR_TWO_SEC = 8'h0E;
  localparam int SDM_NUM_PTRS = 5;

  // Reset and fill values
  localparam logic [7:0] SDM_PTR_RESET = 8'h00;
  localparam logic [7:0] SDM_ZERO_DATA = 8'h00;

  typedef enum logic [1:0] {
    SDM_TGT_RAM,
    SDM_TGT_PTR,
    SDM_TGT_SFR,
    SDM_TGT_NONE
  } sdm_tgt_t;

  typedef enum {
    SDM_IDLE,
    SDM_ACCESS,
    SDM_FINISH
  } sdm_state_t;

  // Implemented special-purpose locations of sectors 0 and 1
  function automatic logic sdm_sfr_used(input logic sec_one,
                                        input logic [6:0] off);
    logic [7:0] o;
    o = {1'b0, off};
    if (!sec_one) begin
      sdm_sfr_used = !(o inside {8'h12, 8'h13, 8'h29, 8'h58});
    end else begin
      sdm_sfr_used = o inside {[8'h1A:8'h1F], [8'h21:8'h28],
                               [8'h2A:8'h31], 8'h33, 8'h34, 8'h36,
                               8'h37, [8'h39:8'h3E], 8'h40,
                               [8'h42:8'h48], 8'h4A, 8'h4B};
    end
  endfunction

endpackage
`default_nettype wire

// file: logic/sdm_ram.sv
// General-purpose data RAM with one write and one registered read port
`timescale 1ns/1ps
`default_nettype none
module sdm_ram #(
  parameter int WORDS = 2048,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(WORDS)-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [$clog2(WORDS)-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [0:WORDS-1];

  // Contents are not cleared; RAM powers up undefined
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// file: logic/sdm_top.sv
// Sectored data memory decoder with pointer-based indirect access
`timescale 1ns/1ps
`default_nettype none
module sdm_top #(
  parameter int SECTORS = sdm_pkg::SDM_SECTORS,
  // One bit per sector-0/1 register, index {sector bit, offset[6:0]}
  parameter logic [255:0] READ_ONLY_MAP = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Execute-stage request
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [sdm_pkg::SDM_ADDR_W-1:0] cpu_addr,
  input wire logic [sdm_pkg::SDM_DATA_W-1:0] cpu_wdata,
  input wire logic cpu_bit_en,
  input wire logic [2:0] cpu_bit_pos,
  input wire logic cpu_bit_val,
  // Execute-stage answer
  output logic cpu_ready,
  output logic cpu_done,
  output logic [sdm_pkg::SDM_DATA_W-1:0] cpu_rdata,
  // Peripheral register port
  output logic sfr_rd,
  output logic sfr_wr,
  output logic sfr_sector,
  output logic [6:0] sfr_offset,
  output logic [sdm_pkg::SDM_DATA_W-1:0] sfr_wdata,
  input wire logic [sdm_pkg::SDM_DATA_W-1:0] sfr_rdata
);
  import sdm_pkg::*;

  localparam int RAM_WORDS = SECTORS * 128;
  localparam int RAM_AW = $clog2(RAM_WORDS);

  // Pointer slot of a sector-0 offset, or SDM_NUM_PTRS when none
  function automatic logic [2:0] ptr_index(input logic [7:0] off);
    case (off)
      SDM_OFF_PTR_ZERO: ptr_index = 3'h0;
      SDM_OFF_PTR_ONE_OFS: ptr_index = 3'h1;
      SDM_OFF_PTR_ONE_SEC: ptr_index = 3'h2;
      SDM_OFF_PTR_TWO_OFS: ptr_index = 3'h3;
      SDM_OFF_PTR_TWO_SEC: ptr_index = 3'h4;
      default: ptr_index = 3'(SDM_NUM_PTRS);
    endcase
  endfunction

  // True for the three indirect port offsets
  function automatic logic is_port(input logic [7:0] off);
    is_port = (off == SDM_OFF_PORT_ZERO) || (off == SDM_OFF_PORT_ONE) ||
              (off == SDM_OFF_PORT_TWO);
  endfunction

  // Byte with one bit forced, the rest kept
  function automatic logic [7:0] apply_bit(input logic [7:0] old,
                                           input logic [2:0] pos,
                                           input logic val);
    logic [7:0] b;
    b = old;
    b[pos] = val;
    apply_bit = b;
  endfunction

  sdm_state_t state_reg;
  logic [7:0] ptr_reg [0:SDM_NUM_PTRS-1];

  // Request capture
  sdm_tgt_t tgt_reg;
  logic [SDM_SECTOR_W-1:0] sec_reg;
  logic [SDM_OFFSET_W-1:0] off_reg;
  logic wr_reg;
  logic bit_reg;
  logic [2:0] pos_reg;
  logic val_reg;
  logic [7:0] wdata_reg;
  logic [7:0] sfr_hold_reg;

  // Resolved location of the incoming request
  logic take;
  logic [SDM_SECTOR_W-1:0] res_sec;
  logic [SDM_OFFSET_W-1:0] res_off;
  sdm_tgt_t res_tgt;
  logic res_ro;
  logic [7:0] ro_index;

  // RAM side
  logic ram_re;
  logic ram_we;
  logic [RAM_AW-1:0] ram_raddr;
  logic [RAM_AW-1:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] ram_q;
  logic [7:0] ptr_old;
  logic [2:0] cur_ptr;

  assign take = cpu_ready && (cpu_rd || cpu_wr);

  always_comb begin
    // Extended operand: upper bits sector, low byte offset
    res_sec = cpu_addr[SDM_ADDR_W-1:SDM_OFFSET_W];
    res_off = cpu_addr[SDM_OFFSET_W-1:0];
    // Ports redirect through their pointers, peripheral registers included
    if (res_sec == '0) begin
      case (cpu_addr[SDM_OFFSET_W-1:0])
        SDM_OFF_PORT_ZERO: begin
          res_sec = '0;
          res_off = ptr_reg[0];
        end
        SDM_OFF_PORT_ONE: begin
          res_sec = ptr_reg[2][SDM_SECTOR_W-1:0];
          res_off = ptr_reg[1];
        end
        SDM_OFF_PORT_TWO: begin
          res_sec = ptr_reg[4][SDM_SECTOR_W-1:0];
          res_off = ptr_reg[3];
        end
        default: begin
          res_sec = cpu_addr[SDM_ADDR_W-1:SDM_OFFSET_W];
          res_off = cpu_addr[SDM_OFFSET_W-1:0];
        end
      endcase
    end
    ro_index = {res_sec[0], res_off[6:0]};
    res_ro = READ_ONLY_MAP[ro_index];
    if (res_off[SDM_GP_SELECT_BIT]) begin
      // High half of a sector is general RAM
      res_tgt = (32'(res_sec) < SECTORS) ? SDM_TGT_RAM
                                         : SDM_TGT_NONE;
    end else if (32'(res_sec) >= SDM_SFR_SECTORS) begin
      res_tgt = SDM_TGT_NONE;
    end else if (res_sec == '0 && is_port(res_off)) begin
      // A pointer aimed at a port finds no storage there
      res_tgt = SDM_TGT_NONE;
    end else if (res_sec == '0 &&
                 ptr_index(res_off) != 3'(SDM_NUM_PTRS)) begin
      res_tgt = SDM_TGT_PTR;
    end else if (sdm_sfr_used(res_sec[0], res_off[6:0])) begin
      res_tgt = SDM_TGT_SFR;
    end else begin
      res_tgt = SDM_TGT_NONE;
    end
  end

  // Sequencer: take, access, finish; ready again after finish
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= SDM_IDLE;
      cpu_ready <= 1'b0;
    end else begin
      case (state_reg)
        SDM_IDLE: begin
          if (take) begin
            state_reg <= SDM_ACCESS;
            cpu_ready <= 1'b0;
          end else begin
            cpu_ready <= 1'b1;
          end
        end
        SDM_ACCESS: state_reg <= SDM_FINISH;
        SDM_FINISH: begin
          state_reg <= SDM_IDLE;
          cpu_ready <= 1'b1;
        end
        default: begin
          state_reg <= SDM_IDLE;
          cpu_ready <= 1'b0;
        end
      endcase
    end
  end

  // Request capture; protected peripheral register writes degrade to no-ops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tgt_reg <= SDM_TGT_NONE;
      sec_reg <= '0;
      off_reg <= '0;
      wr_reg <= 1'b0;
      bit_reg <= 1'b0;
      pos_reg <= '0;
      val_reg <= 1'b0;
      wdata_reg <= SDM_ZERO_DATA;
    end else if (take) begin
      tgt_reg <= res_tgt;
      sec_reg <= res_sec;
      off_reg <= res_off;
      wr_reg <= cpu_wr;
      bit_reg <= cpu_wr && cpu_bit_en;
      pos_reg <= cpu_bit_pos;
      val_reg <= cpu_bit_val;
      wdata_reg <= cpu_wdata;
    end
  end

  // Peripheral strobes last the access cycle only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sfr_rd <= 1'b0;
      sfr_wr <= 1'b0;
      sfr_sector <= 1'b0;
      sfr_offset <= '0;
      sfr_wdata <= SDM_ZERO_DATA;
    end else if (take && res_tgt == SDM_TGT_SFR) begin
      sfr_rd <= !cpu_wr;
      // Bit operations are not offered on peripheral registers
      sfr_wr <= cpu_wr && !cpu_bit_en && !res_ro;
      sfr_sector <= res_sec[0];
      sfr_offset <= res_off[6:0];
      sfr_wdata <= cpu_wdata;
    end else begin
      sfr_rd <= 1'b0;
      sfr_wr <= 1'b0;
    end
  end

  // Peripheral data is sampled at the end of the strobe cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sfr_hold_reg <= SDM_ZERO_DATA;
    end else if (state_reg == SDM_ACCESS) begin
      sfr_hold_reg <= sfr_rd ? sfr_rdata : SDM_ZERO_DATA;
    end
  end

  // RAM index: sector nibble over the low seven offset bits
  assign ram_raddr = RAM_AW'({sec_reg, off_reg[6:0]});
  assign ram_waddr = ram_raddr;
  assign ram_re = (state_reg == SDM_ACCESS) && (tgt_reg == SDM_TGT_RAM);
  assign ram_we = (state_reg == SDM_FINISH) && wr_reg &&
                  (tgt_reg == SDM_TGT_RAM);
  // Read-modify-write keeps the untouched bits
  assign ram_wdata = bit_reg ? apply_bit(ram_q, pos_reg, val_reg)
                             : wdata_reg;

  sdm_ram #(
    .WORDS(RAM_WORDS),
    .DATA_W(SDM_DATA_W)
  ) u_ram (
    .clk(clk),
    .reset(reset),
    .wr_en(ram_we),
    .wr_addr(ram_waddr),
    .wr_data(ram_wdata),
    .rd_en(ram_re),
    .rd_addr(ram_raddr),
    .rd_data(ram_q)
  );

  assign cur_ptr = ptr_index(off_reg);
  assign ptr_old = (cur_ptr < 3'(SDM_NUM_PTRS)) ? ptr_reg[cur_ptr]
                                                : SDM_ZERO_DATA;

  // Pointer bytes behave as ordinary registers
  generate
    for (genvar i = 0; i < SDM_NUM_PTRS; i++) begin : g_ptr
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          ptr_reg[i] <= SDM_PTR_RESET;
        end else if (state_reg == SDM_FINISH && wr_reg &&
                     tgt_reg == SDM_TGT_PTR && cur_ptr == 3'(i)) begin
          ptr_reg[i] <= bit_reg ? apply_bit(ptr_reg[i], pos_reg, val_reg)
                                : wdata_reg;
        end
      end
    end
  endgenerate

  // Answer: old contents of a RAM or pointer location, zero for a peripheral write, one pulse of done
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_done <= 1'b0;
      cpu_rdata <= SDM_ZERO_DATA;
    end else if (state_reg == SDM_FINISH) begin
      cpu_done <= 1'b1;
      case (tgt_reg)
        SDM_TGT_RAM: cpu_rdata <= ram_q;
        SDM_TGT_PTR: cpu_rdata <= ptr_old;
        SDM_TGT_SFR: cpu_rdata <= sfr_hold_reg;
        SDM_TGT_NONE: cpu_rdata <= SDM_ZERO_DATA;
        default: cpu_rdata <= SDM_ZERO_DATA;
      endcase
    end else begin
      cpu_done <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: bench/sdm_sfr_model.sv
// Peripheral register bank answering the decoder's register port
`timescale 1ns/1ps
`default_nettype none
module sdm_sfr_model (
  // Clock
  input wire logic clk,
  // Register port from the decoder
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic sfr_sector,
  input wire logic [6:0] sfr_offset,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata
);
  logic [7:0] regs [0:255];
  logic [7:0] last;
  logic [7:0] idx;
  assign idx = {sfr_sector, sfr_offset};
  initial begin
    last = 8'h00;
    for (int i = 0; i < 256; i++) begin
      regs[i] = i[7:0];
    end
  end
  always @(posedge clk) begin
    if (sfr_wr) begin
      regs[idx] <= sfr_wdata;
    end
    if (sfr_rd) begin
      last <= regs[idx];
    end
  end
  // Released bus shows the inverse of the last byte, never a stale match
  assign sfr_rdata = sfr_rd ? regs[idx] : ~last;
endmodule
`default_nettype wire

// file: bench/sdm_asserts.sv
// Protocol and decode checks on the ports of the decoder top
`timescale 1ns/1ps
`default_nettype none
module sdm_asserts #(
  parameter logic [255:0] READ_ONLY_MAP = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Execute-stage side
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [sdm_pkg::SDM_ADDR_W-1:0] cpu_addr,
  input wire logic [sdm_pkg::SDM_DATA_W-1:0] cpu_wdata,
  input wire logic cpu_bit_en,
  input wire logic cpu_ready,
  input wire logic cpu_done,
  // Register port
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic sfr_sector,
  input wire logic [6:0] sfr_offset,
  input wire logic [sdm_pkg::SDM_DATA_W-1:0] sfr_wdata
);
  import sdm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic take;
  logic direct;
  logic strobe;
  assign take = cpu_ready && (cpu_rd || cpu_wr);
  assign strobe = sfr_rd || sfr_wr;
  // Direct low-half access in sectors 0/1 that is not a port
  assign direct = cpu_addr[11:9] == 3'h0 && !cpu_addr[7] &&
    !(cpu_addr inside {12'h000, 12'h002, 12'h00C});
  AST_ANSWER_TIME: assert property (take |=> !cpu_ready ##1 !cpu_ready
    ##1 (cpu_ready && cpu_done)) else $error("late or missing done");
  AST_DONE_CAUSE: assert property (cpu_done |-> $past(take, 3))
    else $error("done without request");
  AST_DONE_ONE: assert property (cpu_done |=> !cpu_done)
    else $error("done longer than a cycle");
  AST_SFR_PULSE: assert property (strobe |-> $past(take) ##1 !strobe)
    else $error("register strobe malformed");
  AST_RAM_HALF: assert property (take && cpu_addr[7] |=> !strobe)
    else $error("upper half reached registers");
  AST_HIGH_SECT: assert property (take && cpu_addr[11:9] != 3'h0
    |=> !strobe) else $error("sector above 1 reached registers");
  AST_PTR_LOCAL: assert property (take && cpu_addr inside {12'h001,
    12'h003, 12'h004, 12'h00D, 12'h00E} |=> !strobe)
    else $error("pointer access left the decoder");
  AST_UNUSED: assert property (take && cpu_addr inside {12'h012,
    12'h013, 12'h029, 12'h058} |=> !strobe)
    else $error("unused location strobed");
  AST_SFR_ADDR: assert property (take && direct ##1 strobe |->
    sfr_sector == $past(cpu_addr[8]) && sfr_offset == $past(cpu_addr[6:0]))
    else $error("register address wrong");
  AST_PROTECT: assert property (take && cpu_wr && direct &&
    READ_ONLY_MAP[{cpu_addr[8], cpu_addr[6:0]}] |=> !sfr_wr)
    else $error("protected register written");
  AST_WDATA: assert property (take && cpu_wr && !cpu_bit_en ##1 sfr_wr
    |-> sfr_wdata == $past(cpu_wdata)) else $error("register data wrong");
  COV_BIT: cover property (take && cpu_wr && cpu_bit_en);
  COV_SFR_WR: cover property (sfr_wr);
  COV_PORT: cover property (take && cpu_addr inside {12'h000, 12'h00C});
endmodule
bind sdm_top sdm_asserts #(.READ_ONLY_MAP(READ_ONLY_MAP)) u_chk (
  .clk(clk), .reset(reset), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
  .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_bit_en(cpu_bit_en),
  .cpu_ready(cpu_ready), .cpu_done(cpu_done), .sfr_rd(sfr_rd),
  .sfr_wr(sfr_wr), .sfr_sector(sfr_sector), .sfr_offset(sfr_offset),
  .sfr_wdata(sfr_wdata));
`default_nettype wire

// file: bench/test_sectored_data_memory_indirect_access.sv
// Directed testbench for the sectored data memory decoder
`timescale 1ns/1ps
`default_nettype none
module test_sectored_data_memory_indirect_access;
  import sdm_pkg::*;
  logic clk = 1'b0;
  logic reset, cpu_rd, cpu_wr, cpu_bit_en, cpu_bit_val;
  logic cpu_ready, cpu_done, sfr_rd, sfr_wr, sfr_sector;
  logic [2:0] cpu_bit_pos;
  logic [11:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, sfr_wdata, sfr_rdata, q;
  logic [6:0] sfr_offset;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  // Offset 10H of sector 0 is made read-only
  sdm_top #(.READ_ONLY_MAP(256'h10000)) DUT (.clk(clk), .reset(reset),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_bit_en(cpu_bit_en),
    .cpu_bit_pos(cpu_bit_pos), .cpu_bit_val(cpu_bit_val),
    .cpu_ready(cpu_ready), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata),
    .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_sector(sfr_sector),
    .sfr_offset(sfr_offset), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  sdm_sfr_model u_sfr (.clk(clk), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr),
    .sfr_sector(sfr_sector), .sfr_offset(sfr_offset),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  // One access; called at a falling edge, returns at one
  task automatic acc(input logic w, input logic [11:0] a,
      input logic [7:0] d, input logic be, input logic [2:0] bp,
      input logic bv, output logic [7:0] r);
    int n;
    n = 0;
    while (cpu_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cpu_rd = !w;
    cpu_wr = w;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_bit_en = be;
    cpu_bit_pos = bp;
    cpu_bit_val = bv;
    @(negedge clk);
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_bit_en = 1'b0;
    n = 0;
    while (cpu_done !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    if (cpu_done !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t: no completion", $time);
    end
    r = cpu_rdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 1'b0, 3'h0, 1'b0, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, 1'b0, 3'h0, 1'b0, q);
    chk(q, e);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("BAD %0t: run did not finish", $time);
      stop_test();
    end
  end
  initial begin
    {reset, cpu_rd, cpu_wr, cpu_bit_en, cpu_bit_val} = 5'b10000;
    cpu_addr = 12'h000;
    cpu_wdata = 8'h00;
    cpu_bit_pos = 3'h0;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    rd(12'h001, 8'h00);
    for (int s = 0; s < 16; s++) begin
      wr({s[3:0], 4'h8, s[3:0]}, {s[3:0], ~s[3:0]});
    end
    for (int s = 0; s < 16; s++) begin
      rd({s[3:0], 4'h8, s[3:0]}, {s[3:0], ~s[3:0]});
    end
    wr(12'hFFF, 8'hC3);
    rd(12'hFFF, 8'hC3);
    wr(12'h003, 8'h90);
    wr(12'h004, 8'hF3);
    wr(12'h00D, 8'hA0);
    wr(12'h00E, 8'h2F);
    wr(12'h001, 8'h85);
    rd(12'h004, 8'hF3);
    rd(12'h00E, 8'h2F);
    wr(12'h002, 8'h3A);
    rd(12'h390, 8'h3A);
    wr(12'h00C, 8'h4B);
    rd(12'hFA0, 8'h4B);
    wr(12'h000, 8'h6C);
    rd(12'h085, 8'h6C);
    rd(12'h002, 8'h3A);
    wr(12'h003, 8'h91);
    wr(12'h002, 8'h7D);
    rd(12'h391, 8'h7D);
    rd(12'h390, 8'h3A);
    wr(12'h001, 8'h02);
    rd(12'h000, 8'h00);
    wr(12'h000, 8'h99);
    rd(12'h002, 8'h7D);
    rd(12'h012, 8'h00);
    rd(12'h129, 8'h00);
    rd(12'h205, 8'h00);
    wr(12'h014, 8'h3C);
    rd(12'h014, 8'h3C);
    wr(12'h11A, 8'hD2);
    rd(12'h11A, 8'hD2);
    wr(12'h010, 8'h77);
    rd(12'h010, 8'h10);
    wr(12'h2C0, 8'hA5);
    acc(1'b1, 12'h2C0, 8'hFF, 1'b1, 3'h1, 1'b1, q);
    chk(q, 8'hA5);
    acc(1'b1, 12'h2C0, 8'h00, 1'b1, 3'h7, 1'b0, q);
    chk(q, 8'hA7);
    rd(12'h2C0, 8'h27);
    // Bit operation on a pointer byte, then on a peripheral register
    acc(1'b1, 12'h003, 8'hFF, 1'b1, 3'h0, 1'b0, q);
    chk(q, 8'h91);
    rd(12'h003, 8'h90);
    acc(1'b1, 12'h014, 8'hFF, 1'b1, 3'h0, 1'b1, q);
    chk(q, 8'h00);
    rd(12'h014, 8'h3C);
    // Mid-run reset clears pointers but keeps RAM
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    rd(12'h004, 8'h00);
    rd(12'h2C0, 8'h27);
    stop_test();
  end
endmodule
`default_nettype wire
